// ---- logic/cfx_top.sv ----
// Purpose: Acceptance filtering and transmit ordering of a CAN controller node.
// Assumes: One clock; protocol engine strobes are synchronous one-cycle pulses.
// Notes:   Buffers below NUM_DED are dedicated, the rest form a queue or a FIFO.
// Functional notes
// - Standard configs 100/101/110 mark priority hits.
// - Extended configs 100/101/110 mark priority hits.
// - Non-matching extended kept when setting 00/01.
// - Non-matching standard kept when setting 00/01.
// - Priority flag only from priority filter hits.
// - Config 001 to FIFO 0, 010 to FIFO 1.
// - Type 10: reference plus mask filtering.
// - Zero mask bits ignore those identifier bits.
// - Equal identifiers: lowest dedicated buffer first.
// - Queue put index is lowest free buffer.
// - Equal queue identifiers follow stored buffer numbers.
// - FIFO messages leave strictly in written order.
// - Successful cancel: finished flag, pending cleared, no occurred.
// - Started frame completes; occurred set, no cancel.
// - Retransmission enabled: failed buffer restarts immediately unless its cancel was requested.
// - Retransmission disabled: failure clears pending, flags cancel.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module cfx_top #(
	parameter int NUM_TX  = 8,
	parameter int NUM_DED = 4,
	parameter int NUM_STD = 2,
	parameter int NUM_EXT = 2
) (
	// Clock, reset, enable
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire logic                   ce,
	// AXI4-Lite slave
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Received frames from the protocol engine
	input  wire logic                   rx_valid,
	input  wire cfx_pkg::cfx_frame_s    rx_frame,
	output cfx_pkg::cfx_rx_result_s     rx_result,
	output logic                        rx_result_valid,
	// Transmit engine
	output cfx_pkg::cfx_tx_offer_s      tx_offer,
	input  wire logic                   tx_start,
	input  wire logic                   tx_ok,
	input  wire logic                   tx_fail,
	// Interrupt
	output logic                        irq
);
	import cfx_pkg::*;

	if (NUM_TX > 8 || NUM_DED < 1 || NUM_DED >= NUM_TX || NUM_STD > 8 || NUM_EXT > 8
		|| NUM_STD < 1 || NUM_EXT < 1)
	begin : g_chk
		$error("cfx_top: buffer or filter count out of range");
	end

	// ======================================================================
	// Register state
	logic [31:0]                 ctrl;
	logic [CFX_IRQ_W-1:0]        irq_stat;
	logic [CFX_IRQ_W-1:0]        irq_mask;
	logic [NUM_TX-1:0]           pend;
	logic [NUM_TX-1:0]           cncl_req;
	logic [NUM_TX-1:0]           occ;
	logic [NUM_TX-1:0]           cfin;
	cfx_frame_s [NUM_TX-1:0]     tx_id;
	logic [NUM_STD-1:0][31:0]    std_flt;
	logic [2*NUM_EXT-1:0][31:0]  ext_flt;
	logic [2:0]                  fifo_get;
	logic [2:0]                  fifo_put;
	logic [2:0]                  put_idx;
	logic                        active;
	logic [2:0]                  act_idx;

	// ======================================================================
	// AXI4-Lite write path
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        wr_hit;
	logic [31:0] wr_val;

	assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_hold && !s_axi_bvalid;
	assign wr_go         = ce && aw_hold && w_hold && !s_axi_bvalid;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CFX_RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold      <= 1'b0;
				w_hold       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? CFX_RESP_OK : CFX_RESP_SLV;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a <= CFX_RX_STAT && a[1:0] == 2'h0)
			|| (a >= CFX_TX_ID && a < CFX_TX_ID + 8'(4 * NUM_TX) && a[1:0] == 2'h0)
			|| (a >= CFX_STD_FLT && a < CFX_STD_FLT + 8'(4 * NUM_STD) && a[1:0] == 2'h0)
			|| (a >= CFX_EXT_FLT && a < CFX_EXT_FLT + 8'(8 * NUM_EXT) && a[1:0] == 2'h0);
	endfunction
	assign wr_hit = addr_hit(aw_addr);
	assign wr_val = cfx_strb(32'h0000_0000, w_data, w_strb);

	// Word writes of the table registers keep unwritten bytes.
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			ctrl     <= CFX_CTRL_RST;
			irq_mask <= '0;
			tx_id    <= '0;
			std_flt  <= '0;
			ext_flt  <= '0;
		end
		else if (ce && wr_go)
		begin
			if (aw_addr == CFX_CTRL)
				ctrl <= cfx_strb(ctrl, w_data, w_strb);
			if (aw_addr == CFX_IRQ_MASK)
				irq_mask <= wr_val[CFX_IRQ_W-1:0];
			for (int i = 0; i < NUM_TX; i++)
				if (aw_addr == CFX_TX_ID + 8'(4 * i))
					tx_id[i] <= 30'(cfx_strb({2'b00, tx_id[i]}, w_data, w_strb));
			for (int i = 0; i < NUM_STD; i++)
				if (aw_addr == CFX_STD_FLT + 8'(4 * i))
					std_flt[i] <= cfx_strb(std_flt[i], w_data, w_strb);
			for (int i = 0; i < 2 * NUM_EXT; i++)
				if (aw_addr == CFX_EXT_FLT + 8'(4 * i))
					ext_flt[i] <= cfx_strb(ext_flt[i], w_data, w_strb);
		end
	end

	// ======================================================================
	// AXI4-Lite read path
	logic [31:0] rd_val;
	assign s_axi_arready = ce && !s_axi_rvalid;
	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			CFX_CTRL:     rd_val = ctrl;
			CFX_IRQ_STAT: rd_val = 32'(irq_stat);
			CFX_IRQ_MASK: rd_val = 32'(irq_mask);
			CFX_TX_ADD:   rd_val = 32'(pend);
			CFX_TX_CNCL:  rd_val = 32'(cncl_req);
			CFX_TX_PEND:  rd_val = 32'(pend);
			CFX_TX_OCC:   rd_val = 32'(occ);
			CFX_TX_CFIN:  rd_val = 32'(cfin);
			CFX_TX_QSTAT: rd_val = {20'h00000, active, act_idx, 1'b0, fifo_get, 1'b0, put_idx};
			CFX_RX_STAT:  rd_val = 32'(rx_result);
			default:
			begin
				for (int i = 0; i < NUM_TX; i++)
					if (s_axi_araddr == CFX_TX_ID + 8'(4 * i))
						rd_val = 32'(tx_id[i]);
				for (int i = 0; i < NUM_STD; i++)
					if (s_axi_araddr == CFX_STD_FLT + 8'(4 * i))
						rd_val = std_flt[i];
				for (int i = 0; i < 2 * NUM_EXT; i++)
					if (s_axi_araddr == CFX_EXT_FLT + 8'(4 * i))
						rd_val = ext_flt[i];
			end
		endcase
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CFX_RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= addr_hit(s_axi_araddr) ? CFX_RESP_OK : CFX_RESP_SLV;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ======================================================================
	// Acceptance filtering
	function automatic logic flt_match(input logic [1:0] ft, input logic [28:0] id,
		input logic [28:0] ref_id, input logic [28:0] mask);
		case (ft)
			CFX_FT_RANGE:   flt_match = id >= ref_id && id <= mask;
			CFX_FT_DUAL:    flt_match = id == ref_id || id == mask;
			CFX_FT_CLASSIC: flt_match = ((id ^ ref_id) & mask) == '0;
			default:        flt_match = 1'b0;
		endcase
	endfunction

	cfx_rx_result_s next_rx;
	logic [2:0]     hit_cfg;
	logic [1:0]     ga;
	always_comb
	begin
		next_rx = '0;
		hit_cfg = CFX_FC_OFF;
		ga      = rx_frame.ext ? ctrl[CFX_ANE_LSB +: 2] : ctrl[CFX_ANS_LSB +: 2];
		if (!rx_frame.ext)
		begin
			for (int i = NUM_STD - 1; i >= 0; i--)
				if (std_flt[i][29:27] != CFX_FC_OFF && flt_match(std_flt[i][31:30],
					{18'h00000, rx_frame.id[10:0]}, {18'h00000, std_flt[i][26:16]},
					{18'h00000, std_flt[i][10:0]}))
				begin
					next_rx.matched = 1'b1;
					next_rx.index   = 4'(i);
					hit_cfg         = std_flt[i][29:27];
				end
		end
		else
		begin
			for (int i = NUM_EXT - 1; i >= 0; i--)
				if (ext_flt[2*i][31:29] != CFX_FC_OFF && flt_match(ext_flt[2*i+1][31:30],
					rx_frame.id, ext_flt[2*i][28:0], ext_flt[2*i+1][28:0]))
				begin
					next_rx.matched = 1'b1;
					next_rx.index   = 4'(i);
					hit_cfg         = ext_flt[2*i][31:29];
				end
		end
		if (next_rx.matched)
		begin
			// Priority and storage come from the matched element only.
			next_rx.high_priority_message   = hit_cfg == CFX_FC_PRIO || hit_cfg == CFX_FC_PRIO_F0
				|| hit_cfg == CFX_FC_PRIO_F1;
			next_rx.store = hit_cfg != CFX_FC_REJECT && hit_cfg != CFX_FC_PRIO;
			next_rx.fifo1 = hit_cfg == CFX_FC_FIFO1 || hit_cfg == CFX_FC_PRIO_F1;
		end
		else
		begin
			next_rx.store = ga == CFX_GA_FIFO0 || ga == CFX_GA_FIFO1;
			next_rx.fifo1 = ga == CFX_GA_FIFO1;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rx_result       <= '0;
			rx_result_valid <= 1'b0;
		end
		else if (ce)
		begin
			rx_result_valid <= rx_valid;
			if (rx_valid)
				rx_result <= next_rx;
		end
	end

	// ======================================================================
	// Transmit selection
	logic                               fifo_mode;
	logic                               push_ok;
	logic [NUM_TX-1:0]                  elig;
	logic [NUM_TX-1:0][CFX_KEY_W-1:0]   keys;
	logic                               arb_found;
	logic [2:0]                         arb_idx;
	assign fifo_mode = ctrl[CFX_FIFO_BIT];
	always_comb
	begin
		put_idx = fifo_put;
		if (!fifo_mode)
		begin
			put_idx = 3'(NUM_TX - 1);
			for (int i = NUM_TX - 1; i >= NUM_DED; i--)
				if (!pend[i])
					put_idx = 3'(i);
		end
		push_ok = !pend[put_idx];
		for (int i = 0; i < NUM_TX; i++)
		begin
			keys[i] = cfx_key(tx_id[i]);
			// Only the FIFO head competes, so later entries never overtake.
			elig[i] = pend[i] && (i < NUM_DED || !fifo_mode || 3'(i) == fifo_get);
		end
	end
	cfx_tx_arbiter #(
		.NUM      (NUM_TX)
	) cfx_tx_arbiter_inst (
		.eligible (elig),
		.keys     (keys),
		.found    (arb_found),
		.index    (arb_idx)
	);

	// ======================================================================
	// Transmit state
	logic             wr_add;
	logic             wr_cncl;
	logic             wr_push;
	logic             fail_drop;
	logic [NUM_TX-1:0] cncl_now;
	assign wr_add    = wr_go && aw_addr == CFX_TX_ADD;
	assign wr_cncl   = wr_go && aw_addr == CFX_TX_CNCL;
	assign wr_push   = wr_go && aw_addr == CFX_TX_PUSH && push_ok;
	assign fail_drop = tx_fail && (ctrl[CFX_DAR_BIT] || cncl_req[act_idx]);
	always_comb
	begin
		// Cancel succeeds at once only for a buffer the engine has not started.
		cncl_now = cncl_req & pend;
		if (active)
			cncl_now[act_idx] = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			pend     <= '0;
			cncl_req <= '0;
			occ      <= '0;
			cfin     <= '0;
			active   <= 1'b0;
			act_idx  <= 3'h0;
			tx_offer <= '0;
			fifo_get <= 3'(NUM_DED);
			fifo_put <= 3'(NUM_DED);
		end
		else if (ce)
		begin
			pend     <= pend & ~cncl_now;
			cfin     <= cfin | cncl_now;
			cncl_req <= cncl_req & ~cncl_now & pend;
			if (active && tx_ok)
			begin
				active        <= 1'b0;
				pend[act_idx] <= 1'b0;
				occ[act_idx]  <= 1'b1;
				cncl_req[act_idx] <= 1'b0;
			end
			else if (active && fail_drop)
			begin
				active        <= 1'b0;
				pend[act_idx] <= 1'b0;
				cfin[act_idx] <= 1'b1;
				cncl_req[act_idx] <= 1'b0;
			end
			else if (active && tx_fail)
				active <= 1'b0;
			else if (!active && tx_offer.req && tx_start)
			begin
				active  <= 1'b1;
				act_idx <= tx_offer.idx;
			end
			// Requests land after completions so a fresh request wins the same edge.
			// Only requested bits are touched, so a completion of another buffer survives.
			for (int i = 0; i < NUM_TX; i++)
				if (wr_add && wr_val[i])
				begin
					pend[i] <= 1'b1;
					occ[i]  <= 1'b0;
					cfin[i] <= 1'b0;
				end
			if (wr_push)
			begin
				pend[put_idx] <= 1'b1;
				occ[put_idx]  <= 1'b0;
				cfin[put_idx] <= 1'b0;
				if (fifo_mode)
					fifo_put <= (fifo_put == 3'(NUM_TX - 1)) ? 3'(NUM_DED) : fifo_put + 3'h1;
			end
			for (int i = 0; i < NUM_TX; i++)
				if (wr_cncl && wr_val[i] && pend[i])
					cncl_req[i] <= 1'b1;
			// A full FIFO has get equal to put, so the head must still move once it is sent.
			if (fifo_mode && !pend[fifo_get] && (pend >> NUM_DED) != '0)
				fifo_get <= (fifo_get == 3'(NUM_TX - 1)) ? 3'(NUM_DED) : fifo_get + 3'h1;
			// A failed buffer that is not dropped competes again on the next edge.
			if (active && !tx_fail && !tx_ok)
				tx_offer.req <= 1'b0;
			else
			begin
				tx_offer.req   <= arb_found && !(active && (tx_ok || fail_drop) && arb_idx == act_idx)
					&& !(tx_start && tx_offer.req);
				tx_offer.idx   <= arb_idx;
				tx_offer.frame <= tx_id[arb_idx];
			end
		end
	end

	// ======================================================================
	// Interrupts: set wins over a write-one clear in the same cycle.
	logic [CFX_IRQ_W-1:0] irq_set;
	always_comb
	begin
		irq_set = '0;
		irq_set[CFX_IRQ_HPM]  = rx_result_valid && rx_result.high_priority_message;
		irq_set[CFX_IRQ_RX]   = rx_result_valid && rx_result.store;
		irq_set[CFX_IRQ_TXOK] = active && tx_ok;
		irq_set[CFX_IRQ_CFIN] = (active && fail_drop) || (cncl_now != '0);
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			irq_stat <= '0;
		else if (ce)
			irq_stat <= (irq_stat & ~((wr_go && aw_addr == CFX_IRQ_STAT)
				? wr_val[CFX_IRQ_W-1:0] : '0)) | irq_set;
	end
	assign irq = |(irq_stat & irq_mask);

	// ======================================================================
	// Checks
	a_hpm_only_prio: assert property (@(posedge mclk) disable iff (!reset_n)
		irq_set[CFX_IRQ_HPM] |-> rx_result.matched) else $error("priority flag without filter hit");
	a_classic_zero: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && rx_valid && rx_frame.ext && ext_flt[0][31:29] == CFX_FC_FIFO0
		&& ext_flt[1][31:30] == CFX_FT_CLASSIC && ext_flt[1][28:0] == '0)
		|=> rx_result.store && !rx_result.fifo1 && !rx_result.high_priority_message)
		else $error("zero mask did not accept");
	a_nonmatch_std: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && rx_valid && !next_rx.matched && !rx_frame.ext && !ctrl[CFX_ANS_LSB+1])
		|=> rx_result.store) else $error("non-matching standard frame dropped");
	a_prio_std: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && rx_valid && !rx_frame.ext && next_rx.matched && hit_cfg[2] && hit_cfg != 3'h7)
		|=> rx_result.high_priority_message ##1 irq_stat[CFX_IRQ_HPM]) else $error("priority hit lost");
	a_ok_occurred: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && active && tx_ok) |=> occ[$past(act_idx)] && !cfin[$past(act_idx)]
		&& !pend[$past(act_idx)]) else $error("completion not recorded");
	a_dar_drop: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && active && tx_fail && ctrl[CFX_DAR_BIT])
		|=> cfin[$past(act_idx)] && !active) else $error("disabled retry not dropped");
	sequence s_fail_retry;
		ce && active && tx_fail && !fail_drop && !wr_go;
	endsequence
	a_retry_now: assert property (@(posedge mclk) disable iff (!reset_n)
		s_fail_retry ##1 (ce && !wr_go)[*1] |-> tx_offer.req) else $error("no retransmission");
	a_cancel_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		(ce && cncl_now != '0) |=> (cfin & $past(cncl_now)) == $past(cncl_now)
		&& (occ & $past(cncl_now)) == '0) else $error("cancel not finished");
	a_fifo_head: assert property (@(posedge mclk) disable iff (!reset_n)
		(tx_offer.req && fifo_mode && tx_offer.idx >= 3'(NUM_DED)) |-> tx_offer.idx == fifo_get)
		else $error("FIFO entry overtook head");
endmodule

// ---- pkg/cfx_pkg.sv ----
// Purpose: Shared constants, types and helpers of the CAN filter and transmit order block.
// Assumes: 32-bit AXI4-Lite register access, one word per register.
// Notes:   Identifier keys order frames the way the bus arbitrates them.
package cfx_pkg;
	// ======================================================================
	// Register map
	localparam logic [7:0] CFX_CTRL     = 8'h00;
	localparam logic [7:0] CFX_IRQ_STAT = 8'h04;
	localparam logic [7:0] CFX_IRQ_MASK = 8'h08;
	localparam logic [7:0] CFX_TX_ADD   = 8'h0C;
	localparam logic [7:0] CFX_TX_CNCL  = 8'h10;
	localparam logic [7:0] CFX_TX_PEND  = 8'h14;
	localparam logic [7:0] CFX_TX_OCC   = 8'h18;
	localparam logic [7:0] CFX_TX_CFIN  = 8'h1C;
	localparam logic [7:0] CFX_TX_QSTAT = 8'h20;
	localparam logic [7:0] CFX_TX_PUSH  = 8'h24;
	localparam logic [7:0] CFX_RX_STAT  = 8'h28;
	localparam logic [7:0] CFX_TX_ID    = 8'h40;
	localparam logic [7:0] CFX_STD_FLT  = 8'h80;
	localparam logic [7:0] CFX_EXT_FLT  = 8'hC0;
	// ======================================================================
	// Field positions
	localparam int CFX_DAR_BIT  = 0;
	localparam int CFX_FIFO_BIT = 1;
	localparam int CFX_ANS_LSB  = 2;
	localparam int CFX_ANE_LSB  = 4;
	localparam int CFX_IRQ_HPM  = 0;
	localparam int CFX_IRQ_TXOK = 1;
	localparam int CFX_IRQ_CFIN = 2;
	localparam int CFX_IRQ_RX   = 3;
	localparam int CFX_IRQ_W    = 4;
	localparam int CFX_EXT_BIT  = 29;
	localparam logic [31:0] CFX_CTRL_RST = 32'h0000_0000;
	// ======================================================================
	// Filter encodings
	localparam logic [1:0] CFX_FT_RANGE   = 2'h0;
	localparam logic [1:0] CFX_FT_DUAL    = 2'h1;
	localparam logic [1:0] CFX_FT_CLASSIC = 2'h2;
	localparam logic [2:0] CFX_FC_OFF     = 3'h0;
	localparam logic [2:0] CFX_FC_FIFO0   = 3'h1;
	localparam logic [2:0] CFX_FC_FIFO1   = 3'h2;
	localparam logic [2:0] CFX_FC_REJECT  = 3'h3;
	localparam logic [2:0] CFX_FC_PRIO    = 3'h4;
	localparam logic [2:0] CFX_FC_PRIO_F0 = 3'h5;
	localparam logic [2:0] CFX_FC_PRIO_F1 = 3'h6;
	localparam logic [1:0] CFX_GA_FIFO0   = 2'h0;
	localparam logic [1:0] CFX_GA_FIFO1   = 2'h1;
	localparam logic [1:0] CFX_RESP_OK    = 2'h0;
	localparam logic [1:0] CFX_RESP_SLV   = 2'h2;
	localparam int CFX_KEY_W = 30;
	// ======================================================================
	// Carriers
	typedef struct packed
	{
		logic        ext;
		logic [28:0] id;
	} cfx_frame_s;
	typedef struct packed
	{
		logic       store;
		logic       fifo1;
		logic       high_priority_message;
		logic       matched;
		logic [3:0] index;
	} cfx_rx_result_s;
	typedef struct packed
	{
		logic       req;
		logic [2:0] idx;
		cfx_frame_s frame;
	} cfx_tx_offer_s;
	// Lower key wins the bus: a standard frame beats an extended one of equal base.
	function automatic logic [CFX_KEY_W-1:0] cfx_key(input cfx_frame_s f);
		cfx_key = f.ext ? {f.id[28:18], 1'b1, f.id[17:0]} : {f.id[10:0], 1'b0, 18'h00000};
	endfunction
	function automatic logic [31:0] cfx_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		cfx_strb = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				cfx_strb[8*b +: 8] = nw[8*b +: 8];
		end
	endfunction
endpackage

// ---- logic/cfx_tx_arbiter.sv ----
// Purpose: Picks the eligible transmit buffer with the highest bus priority.
// Assumes: Keys come from cfx_key, one per buffer.
// Notes:   Strict compare keeps the lower buffer number on equal keys.
`timescale 1ns/1ps
module cfx_tx_arbiter #(
	parameter int NUM = 8
) (
	// Candidates
	input  wire logic [NUM-1:0]                     eligible,
	input  wire logic [NUM-1:0][cfx_pkg::CFX_KEY_W-1:0] keys,
	// Choice
	output logic                                    found,
	output logic [2:0]                              index
);
	import cfx_pkg::*;
	if (NUM < 1 || NUM > 8)
	begin : g_chk
		$error("cfx_tx_arbiter: NUM out of range");
	end
	logic [CFX_KEY_W-1:0] best;
	always_comb
	begin
		found = 1'b0;
		index = 3'h0;
		best  = '1;
		for (int i = 0; i < NUM; i++)
		begin
			if (eligible[i] && (!found || keys[i] < best))
			begin
				found = 1'b1;
				index = 3'(i);
				best  = keys[i];
			end
		end
	end
endmodule

// ---- tb/cfx_engine_model.sv ----
// Purpose: Transmit engine on the far side of the block.
// Assumes: Starts any offer while go is high.
// Notes:   Each frame ends four cycles after its start.
`timescale 1ns/1ps
module cfx_engine_model (
	// Clock and control
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire logic                   go,
	input  wire logic                   do_fail,
	// Engine handshake
	input  wire cfx_pkg::cfx_tx_offer_s tx_offer,
	output logic                        tx_start,
	output logic                        tx_ok,
	output logic                        tx_fail
);
	import cfx_pkg::*;
	logic [1:0] busy;
	// ==========================================================
	// Frame engine
	// Outcome pulses only while a frame runs, as the block expects.
	always_ff @(posedge mclk)
	begin
		tx_start <= reset_n && busy == 2'h0 && go && tx_offer.req && !tx_start;
		tx_ok <= reset_n && busy == 2'h1 && !do_fail;
		tx_fail <= reset_n && busy == 2'h1 && do_fail;
		if (!reset_n)
			busy <= 2'h0;
		else if (tx_start)
			busy <= 2'h3;
		else if (busy != 2'h0)
			busy <= busy - 2'h1;
	end
endmodule

// ---- tb/cfx_top_bench.sv ----
// Purpose: Self-checking bench of the filter and transmit order block.
// Assumes: One register access at a time.
// Notes:   Expectations come from the filter and order encodings.
`timescale 1ns/1ps
module cfx_top_bench;
	import cfx_pkg::*;
	logic           mclk = 0, reset_n = 0, ce = 1, go = 0, do_fail = 0, rx_valid = 0;
	logic [7:0]     s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic [3:0]     s_axi_wstrb = 4'hF;
	logic           s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic           s_axi_bready = 0, s_axi_rready = 0;
	logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]     s_axi_bresp, s_axi_rresp, r;
	logic           rx_result_valid, tx_start, tx_ok, tx_fail, irq;
	cfx_frame_s     rx_frame = '0;
	cfx_rx_result_s rx_result;
	cfx_tx_offer_s  tx_offer;
	int             err_total = 0, n_compared = 0;
	logic [2:0]     order[$];
	cfx_top cfx_top_inst (.*);
	cfx_engine_model cfx_engine_model_inst (.*);
	always #4 mclk = ~mclk;
	always @(posedge mclk)
		if (tx_start && tx_offer.req)
			order.push_back(tx_offer.idx);
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic stop(input string m);
		chk(0, 1, m);
		end_sim;
	endtask
	// Write when w is high, else read; answer lands in q and r.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw, tb;
		int n;
		@(posedge mclk);
		pa = 1;
		pw = w;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		for (n = 0; n < 40; n++)
		begin
			@(negedge mclk);
			ta = pa & (w ? s_axi_awready : s_axi_arready);
			tw = pw & s_axi_wready;
			tb = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge mclk);
			s_axi_awvalid <= s_axi_awvalid & !ta;
			s_axi_arvalid <= s_axi_arvalid & !ta;
			s_axi_wvalid <= s_axi_wvalid & !tw;
			pa = pa & !ta;
			pw = pw & !tw;
			if (tb)
				break;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (n == 40)
			stop("bus hang");
	endtask
	// Expected is {store, fifo1, hpm, matched}.
	task automatic rx(input logic e, input logic [28:0] id, input logic [3:0] exp);
		@(posedge mclk);
		rx_valid <= 1;
		rx_frame <= '{e, id};
		@(posedge mclk);
		rx_valid <= 0;
		@(negedge mclk);
		chk({rx_result_valid, rx_result}, {1'b1, exp, 4'h0}, "rx result");
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 30; n++)
		begin
			bus(0, CFX_TX_PEND, 0);
			if (q == 0)
				break;
		end
		if (n == 30)
			stop("tx hang");
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_filter;
		bus(1, CFX_IRQ_MASK, 32'h1);
		for (int c = 4; c < 7; c++)
		begin
			bus(1, CFX_STD_FLT, {2'h2, 3'(c), 11'h123, 5'h0, 11'h7FF});
			rx(0, 29'h123, {c != 4, c == 6, 2'h3});
		end
		bus(0, CFX_IRQ_STAT, 0);
		chk(irq, 1, "irq");
		bus(1, CFX_IRQ_STAT, 32'h1);
		chk(irq, 0, "irq clear");
		rx(1, 29'h0ABCDEF, 4'h8);
		bus(1, CFX_CTRL, 32'h4);
		rx(0, 29'h7, 4'hC);
		bus(0, CFX_IRQ_STAT, 0);
		chk(q[0], 0, "hpm after global");
		bus(1, CFX_EXT_FLT, {3'h5, 29'h0ABCDEF});
		bus(1, 8'hC4, 32'h9FFFFFFF);
		rx(1, 29'h0ABCDEF, 4'hB);
		bus(1, 8'hC4, 32'h80000000);
		for (int c = 1; c < 3; c++)
		begin
			bus(1, CFX_EXT_FLT, {3'(c), 29'h55});
			rx(1, 29'h1234567, {1'b1, c == 2, 2'h1});
		end
		$display("filter test done");
	endtask
	task automatic t_tx;
		int k;
		for (int i = 0; i < 3; i++)
			bus(1, 8'(CFX_TX_ID + 4 * i), 32'h200);
		bus(1, 8'h4C, 32'h100);
		go <= 1;
		bus(1, CFX_TX_ADD, 32'hF);
		wait_idle;
		chk({order[0], order[1], order[2], order[3]}, 12'h60A, "order");
		bus(0, CFX_TX_OCC, 0);
		chk(q, 32'hF, "occurred");
		go <= 0;
		bus(1, CFX_TX_ADD, 32'h1);
		bus(1, CFX_TX_CNCL, 32'h1);
		wait_idle;
		bus(0, CFX_TX_CFIN, 0);
		chk(q[0], 1, "cancel flag");
		bus(0, CFX_TX_OCC, 0);
		chk(q[0], 0, "cancel occ");
		order.delete();
		bus(1, CFX_CTRL, 32'h1);
		do_fail <= 1;
		go <= 1;
		bus(1, CFX_TX_ADD, 32'h2);
		wait_idle;
		bus(0, CFX_TX_CFIN, 0);
		chk({order.size() == 1, q[1]}, 2'h3, "no retry");
		go <= 0;
		do_fail <= 0;
		bus(0, CFX_TX_QSTAT, 0);
		chk(q[2:0], 3'h4, "put index");
		bus(1, CFX_TX_PUSH, 32'h0);
		bus(0, CFX_TX_QSTAT, 0);
		chk(q[2:0], 3'h5, "put next");
		go <= 1;
		wait_idle;
		bus(1, CFX_CTRL, 32'h2);
		go <= 0;
		for (int i = 4; i < 7; i++)
		begin
			bus(1, 8'(CFX_TX_ID + 4 * i), 32'(32'h700 - 32'h100 * i));
			bus(1, CFX_TX_PUSH, 32'h0);
		end
		order.delete();
		do_fail <= 1;
		go <= 1;
		repeat (12) @(posedge mclk);
		do_fail <= 0;
		wait_idle;
		chk({order[0], order[1]}, 6'h24, "retry");
		k = order.size();
		chk({order[k-3], order[k-2], order[k-1]}, 9'h12E, "fifo order");
		$display("transmit test done");
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		reset_n <= 1;
		bus(0, CFX_CTRL, 0);
		chk(q, CFX_CTRL_RST, "ctrl reset");
		bus(0, 8'h3C, 0);
		chk(r, CFX_RESP_SLV, "unmapped read");
		bus(1, 8'h3C, 32'h1);
		chk(r, CFX_RESP_SLV, "unmapped write");
		$display("register test done");
		t_filter;
		t_tx;
		end_sim;
	end
endmodule
